// File: design/brf_pkg.sv
// Purpose: Shared constants and carrier types of the boot ROM/Flash interface.
// Assumes: 32-bit APB register slave, 100 MHz sys_clk.
// Notes: Base addresses are held in 1MB units (address bits 31:20).
`default_nettype none
package brf_pkg;
  // APB register offsets, one aligned word each
  localparam logic [7:0] BRF_OFF_CTRL_A = 8'h00;
  localparam logic [7:0] BRF_OFF_BASE_A = 8'h04;
  localparam logic [7:0] BRF_OFF_CTRL_B = 8'h08;
  localparam logic [7:0] BRF_OFF_BASE_B = 8'h0C;
  // Control register field positions
  localparam int BRF_CTRL_EN = 0;
  localparam int BRF_CTRL_WE = 1;
  localparam int BRF_CTRL_RV = 2;
  localparam int BRF_CTRL_WIDTH = 3;
  localparam int BRF_CTRL_SIZE_LSB = 4;
  localparam int BRF_CTRL_TIME_LSB = 8;
  localparam int BRF_BASE_LSB = 20;
  // Reset values of the base, size and access time fields
  localparam logic [11:0] BRF_BASE_A_SMALL = 12'hFF0;
  localparam logic [11:0] BRF_BASE_A_LARGE = 12'hF40;
  localparam logic [11:0] BRF_BASE_B_RST = 12'hFF8;
  localparam logic [2:0] BRF_SIZE_RST = 3'h0;
  localparam logic [3:0] BRF_TIME_RST = 4'hF;
  // Reset vector window, first 1MB of a block
  localparam logic [11:0] BRF_RV_WINDOW = 12'hFFF;
  // Transfer sizes accepted for writes
  localparam logic [3:0] BRF_WR_SIZE_NARROW = 4'h1;
  localparam logic [3:0] BRF_WR_SIZE_WIDE = 4'h4;
  // Pin data passes two flops before use
  localparam logic [4:0] BRF_SYNC_LAT = 5'h2;
  localparam logic [1:0] BRF_LAST_STEP = 2'h3;
  localparam logic [1:0] BRF_LAST_BEAT = 2'h3;

  typedef enum logic [1:0] {
    BRF_ST_IDLE = 2'b00,
    BRF_ST_RUN = 2'b01,
    BRF_ST_ACK = 2'b10
  } brf_state_t;

  // Software view of one block
  typedef struct packed {
    logic en;
    logic we;
    logic rv;
    logic wide;
    logic [2:0] size;
    logic [3:0] atime;
    logic [11:0] base;
  } brf_blk_t;

  // Processor request, held until the final acknowledge
  typedef struct packed {
    logic valid;
    logic wr;
    logic burst;
    logic [3:0] size;
    logic [31:0] addr;
    logic [63:0] wdata;
  } brf_cpu_req_t;

  typedef struct packed {
    logic ack;
    logic last;
    logic [63:0] rdata;
  } brf_cpu_rsp_t;

  // Device side pins: upper half is data bits 63:32
  typedef struct packed {
    logic [22:0] addr;
    logic ce_a;
    logic ce_b;
    logic oe;
    logic we;
    logic upper;
    logic lower;
    logic [63:0] wdata;
    logic wdata_oe;
  } brf_flash_t;

  // Jumper straps
  typedef struct packed {
    logic rv_a;
    logic rv_b;
    logic wide_a;
    logic wide_b;
    logic big_a;
  } brf_strap_t;
endpackage : brf_pkg
`default_nettype wire

// File: design/brf_ctrl.sv
// Purpose: Boot ROM/Flash controller: decode, enables, width handling, access timing.
// Assumes: Processor holds its request until acknowledged; straps steady around reset.
// Notes: No ECC on this path; straps and pin data pass two flops first.
`timescale 1ns/10ps
`default_nettype none
module brf_ctrl
  import brf_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire brf_strap_t strap_pins,
  input wire brf_cpu_req_t cpu_req,
  output brf_cpu_rsp_t cpu_rsp,
  output logic cpu_sel,
  output brf_flash_t flash_out,
  input wire logic [63:0] flash_rdata
);

  typedef struct packed {
    brf_state_t st;
    brf_blk_t blk_a;
    brf_blk_t blk_b;
    brf_strap_t strap_s1;
    brf_strap_t strap_s2;
    logic [63:0] rd_s1;
    logic [63:0] rd_s2;
    logic [31:0] prdata;
    logic cur_b;
    logic cur_wide;
    logic cur_wr;
    logic cur_multi;
    logic [25:0] off;
    logic [1:0] step;
    logic [1:0] beat;
    logic [4:0] cnt;
    logic [63:0] rbuf;
    brf_cpu_rsp_t rsp;
    brf_flash_t fl;
  } brf_regs_t;

  brf_regs_t r_q;
  brf_regs_t r_d;

  // Address match of a block at its base, size sets the compared bits
  // Base bits below the block size are ignored, so a block sits on its own boundary
  function automatic logic base_hit(input brf_blk_t b, input logic [31:0] a);
    logic [11:0] m;
    m = 12'hFFF << b.size;
    return (a[31:20] & m) == (b.base & m);
  endfunction

  // Offset inside a block for a normal decode
  // Bits above the block size are dropped, so a small block repeats nowhere inside it
  function automatic logic [25:0] blk_off(input brf_blk_t b, input logic [31:0] a);
    logic [11:0] m;
    m = 12'hFFF << b.size;
    return {a[25:20] & ~m[5:0], a[19:0]};
  endfunction

  // Packing of the control word seen by software
  function automatic logic [31:0] ctrl_word(input brf_blk_t b);
    logic [31:0] w;
    // Unused bits read as zero
    w = 32'h0000_0000;
    w[BRF_CTRL_EN] = b.en;
    w[BRF_CTRL_WE] = b.we;
    w[BRF_CTRL_RV] = b.rv;
    w[BRF_CTRL_WIDTH] = b.wide;
    w[BRF_CTRL_SIZE_LSB +: 3] = b.size;
    w[BRF_CTRL_TIME_LSB +: 4] = b.atime;
    return w;
  endfunction

  // Software update of a block; width stays as strapped
  function automatic brf_blk_t ctrl_wr(input brf_blk_t b, input logic [31:0] w);
    brf_blk_t n;
    n = b;
    n.en = w[BRF_CTRL_EN];
    n.we = w[BRF_CTRL_WE];
    n.rv = w[BRF_CTRL_RV];
    // Code 7 would span 128MB and alias beyond a block's reach, so it is held at 64MB
    n.size = (w[BRF_CTRL_SIZE_LSB +: 3] == 3'h7) ? 3'h6 : w[BRF_CTRL_SIZE_LSB +: 3];
    n.atime = w[BRF_CTRL_TIME_LSB +: 4];
    return n;
  endfunction

  // Cycles one device access holds its strobes, pin sync included
  // The sync flops add latency the count must cover, else stale pin data is taken
  function automatic logic [4:0] acc_cycles(input brf_blk_t b);
    logic [4:0] t;
    t = (b.atime == 4'h0) ? 5'h01 : {1'b0, b.atime};
    return t + BRF_SYNC_LAT - 5'h01;
  endfunction

  // Narrow device address: bus bits 23:3 joined with the two lowest
  // Bit 2 picks the half, so it never reaches the device address
  function automatic logic [22:0] narrow_addr(input logic [25:0] o, input logic [1:0] s);
    return {o[23:3], s};
  endfunction

  logic rd_a;
  logic rd_b;
  logic any_a;
  logic any_b;
  logic rv_hit_a;
  logic rv_hit_b;
  logic take_b;
  brf_blk_t cur_blk;
  logic wr_ok;

  // Decode: normal reads need the enable, writes need either enable
  // The window compares all top twelve bits, whatever size is programmed
  always_comb begin
    rv_hit_a = r_q.blk_a.rv && (cpu_req.addr[31:20] == BRF_RV_WINDOW);
    rv_hit_b = r_q.blk_b.rv && (cpu_req.addr[31:20] == BRF_RV_WINDOW);
    rd_a = (r_q.blk_a.en && base_hit(r_q.blk_a, cpu_req.addr)) || rv_hit_a;
    rd_b = (r_q.blk_b.en && base_hit(r_q.blk_b, cpu_req.addr)) || rv_hit_b;
    any_a = cpu_req.wr ? ((r_q.blk_a.en || r_q.blk_a.we) && base_hit(r_q.blk_a, cpu_req.addr)) || rv_hit_a
                       : rd_a;
    any_b = cpu_req.wr ? ((r_q.blk_b.en || r_q.blk_b.we) && base_hit(r_q.blk_b, cpu_req.addr)) || rv_hit_b
                       : rd_b;
    // Block A wins an overlap so a single block ever answers
    take_b = !any_a && any_b;
    // Tells the processor bus that this controller owns the cycle
    cpu_sel = cpu_req.valid && (any_a || any_b);
  end

  // Write acceptance by the strapped width and the write enable
  // A refused write still ends on the bus, it only never strobes the device
  always_comb begin
    cur_blk = take_b ? r_q.blk_b : r_q.blk_a;
    if (cur_blk.wide) begin
      wr_ok = cur_blk.we && (cpu_req.size == BRF_WR_SIZE_WIDE) && (cpu_req.addr[1:0] == 2'b00);
    end else begin
      wr_ok = cur_blk.we && (cpu_req.size == BRF_WR_SIZE_NARROW);
    end
  end

  // APB: zero-wait access phase, read word latched in setup
  // Error response is combinational so it stands in the very access cycle
  assign pready = 1'b1;
  assign pslverr = psel && penable && !(paddr[7:0] inside {BRF_OFF_CTRL_A, BRF_OFF_BASE_A,
                                                          BRF_OFF_CTRL_B, BRF_OFF_BASE_B});
  assign prdata = r_q.prdata;
  assign cpu_rsp = r_q.rsp;
  assign flash_out = r_q.fl;

  brf_blk_t sel_blk;
  logic [25:0] new_off;
  logic [4:0] new_cnt;

  // Next-state of the whole controller
  // Request fields are read live; the master holds them until the last ack
  always_comb begin
    r_d = r_q;
    sel_blk = r_q.cur_b ? r_q.blk_b : r_q.blk_a;
    new_off = 26'h0;
    new_cnt = 5'h00;
    // Synchronisers run through reset so straps are settled at release
    r_d.strap_s1 = strap_pins;
    r_d.strap_s2 = r_q.strap_s1;
    r_d.rd_s1 = flash_rdata;
    r_d.rd_s2 = r_q.rd_s1;
    // Ack and last are one-cycle pulses unless a branch below raises them
    r_d.rsp.ack = 1'b0;
    r_d.rsp.last = 1'b0;

    // Register reads are captured in the setup cycle
    if (psel && !penable) begin
      unique case (paddr[7:0])
        BRF_OFF_CTRL_A: r_d.prdata = ctrl_word(r_q.blk_a);
        BRF_OFF_BASE_A: r_d.prdata = {r_q.blk_a.base, 20'h00000};
        BRF_OFF_CTRL_B: r_d.prdata = ctrl_word(r_q.blk_b);
        BRF_OFF_BASE_B: r_d.prdata = {r_q.blk_b.base, 20'h00000};
        default: r_d.prdata = 32'h0000_0000;
      endcase
    end
    // Register writes take effect on the access edge
    if (psel && penable && pwrite) begin
      unique case (paddr[7:0])
        BRF_OFF_CTRL_A: r_d.blk_a = ctrl_wr(r_q.blk_a, pwdata);
        BRF_OFF_BASE_A: r_d.blk_a.base = pwdata[31:BRF_BASE_LSB];
        BRF_OFF_CTRL_B: r_d.blk_b = ctrl_wr(r_q.blk_b, pwdata);
        BRF_OFF_BASE_B: r_d.blk_b.base = pwdata[31:BRF_BASE_LSB];
        default: ;
      endcase
    end

    // Data path moves raw device bits, no check bits anywhere
    unique case (r_q.st)
      BRF_ST_IDLE: begin
        if (cpu_req.valid && (any_a || any_b)) begin
          new_off = (take_b ? rv_hit_b : rv_hit_a) ? {6'h00, cpu_req.addr[19:0]}
                                                   : blk_off(cur_blk, cpu_req.addr);
          new_cnt = acc_cycles(cur_blk);
          r_d.cur_b = take_b;
          r_d.cur_wide = cur_blk.wide;
          r_d.cur_wr = cpu_req.wr;
          r_d.off = new_off;
          r_d.beat = 2'h0;
          r_d.cnt = new_cnt;
          r_d.rbuf = 64'h0;
          r_d.fl.ce_a = !take_b;
          r_d.fl.ce_b = take_b;
          // Writes are one device access each; burst writes are not supported
          if (cpu_req.wr) begin
            if (wr_ok) begin
              r_d.st = BRF_ST_RUN;
              r_d.fl.we = 1'b1;
              r_d.fl.wdata_oe = 1'b1;
              r_d.fl.upper = !new_off[2];
              r_d.fl.lower = new_off[2];
              if (cur_blk.wide) begin
                r_d.fl.addr = new_off[25:3];
                // Both halves carry the word; only the selected half is strobed
                r_d.fl.wdata = new_off[2] ? {2{cpu_req.wdata[31:0]}} : {2{cpu_req.wdata[63:32]}};
              end else begin
                r_d.fl.addr = narrow_addr(new_off, new_off[1:0]);
                // The addressed byte goes out on both byte lanes
                for (int i = 0; i < 8; i++) begin
                  if (new_off[2:0] == 3'(i)) begin
                    r_d.fl.wdata = {2{24'h000000, cpu_req.wdata[63 - 8 * i -: 8]}};
                  end
                end
              end
            end else begin
              // Refused write: answered at once, no strobe reaches the device
              r_d.st = BRF_ST_ACK;
              r_d.fl.ce_a = 1'b0;
              r_d.fl.ce_b = 1'b0;
              r_d.rsp.ack = 1'b1;
              r_d.rsp.last = 1'b1;
            end
          end else begin
            r_d.st = BRF_ST_RUN;
            r_d.fl.oe = 1'b1;
            // Both halves are read; capture keeps both, none is picked by the offset
            r_d.fl.upper = 1'b1;
            r_d.fl.lower = 1'b1;
            // Narrow reads wider than a byte walk all four byte slots
            r_d.cur_multi = !cur_blk.wide && (cpu_req.burst || cpu_req.size != 4'h1);
            r_d.step = (!cur_blk.wide && !cpu_req.burst && cpu_req.size == 4'h1) ? new_off[1:0] : 2'h0;
            if (cpu_req.burst) begin
              r_d.off = {new_off[25:5], 5'h00};
            end
            if (cur_blk.wide) begin
              r_d.fl.addr = cpu_req.burst ? {new_off[25:5], 2'h0} : new_off[25:3];
            end else begin
              r_d.fl.addr = narrow_addr(cpu_req.burst ? {new_off[25:5], 5'h00} : new_off,
                                        (cpu_req.burst || cpu_req.size != 4'h1) ? 2'h0 : new_off[1:0]);
            end
          end
        end
      end
      BRF_ST_RUN: begin
        // Strobes and address stand still while the access time counts down
        if (r_q.cnt != 5'h00) begin
          r_d.cnt = r_q.cnt - 5'h01;
        end else if (r_q.cur_wr) begin
          // Single device write finished
          r_d.st = BRF_ST_ACK;
          r_d.fl = '0;
          r_d.rsp.ack = 1'b1;
          r_d.rsp.last = 1'b1;
        end else begin
          r_d.cnt = acc_cycles(sel_blk);
          if (r_q.cur_wide) begin
            // A wide access returns the whole doubleword at once
            r_d.rbuf = r_q.rd_s2;
          end else begin
            // Upper byte fills slot step, lower byte fills slot step+4
            for (int i = 0; i < 4; i++) begin
              if (r_q.step == 2'(i)) begin
                r_d.rbuf[63 - 8 * i -: 8] = r_q.rd_s2[39:32];
                r_d.rbuf[31 - 8 * i -: 8] = r_q.rd_s2[7:0];
              end
            end
          end
          if (r_q.cur_multi && r_q.step != BRF_LAST_STEP) begin
            r_d.step = r_q.step + 2'h1;
            r_d.fl.addr = narrow_addr(r_q.off, r_q.step + 2'h1);
          end else begin
            // One beat complete: hand data out
            r_d.rsp.ack = 1'b1;
            r_d.rsp.rdata = r_d.rbuf;
            if (cpu_req.burst && r_q.beat != BRF_LAST_BEAT) begin
              r_d.beat = r_q.beat + 2'h1;
              r_d.step = 2'h0;
              // Next doubleword of the burst; strobes stay up between beats
              r_d.off = r_q.off + 26'h0000008;
              r_d.fl.addr = r_q.cur_wide ? r_d.off[25:3] : narrow_addr(r_d.off, 2'h0);
            end else begin
              r_d.st = BRF_ST_ACK;
              r_d.rsp.last = 1'b1;
              r_d.fl = '0;
            end
          end
        end
      end
      BRF_ST_ACK: begin
        // Lets the master drop the finished request
        r_d.st = BRF_ST_IDLE;
      end
      default: r_d.st = BRF_ST_IDLE;
    endcase

    // Reset: enables cleared, straps captured from the settled flops
    // Reset must last three edges, or the straps are still unknown here
    if (reset) begin
      r_d.st = BRF_ST_IDLE;
      r_d.prdata = 32'h0000_0000;
      r_d.cur_b = 1'b0;
      r_d.cur_wide = 1'b0;
      r_d.cur_wr = 1'b0;
      r_d.cur_multi = 1'b0;
      r_d.off = 26'h0;
      r_d.step = 2'h0;
      r_d.beat = 2'h0;
      r_d.cnt = 5'h00;
      r_d.rbuf = 64'h0;
      r_d.rsp = '0;
      r_d.fl = '0;
      r_d.blk_a.en = 1'b0;
      r_d.blk_a.we = 1'b0;
      r_d.blk_b.en = 1'b0;
      r_d.blk_b.we = 1'b0;
      r_d.blk_a.rv = r_q.strap_s2.rv_a;
      r_d.blk_b.rv = r_q.strap_s2.rv_b;
      r_d.blk_a.wide = r_q.strap_s2.wide_a;
      r_d.blk_b.wide = r_q.strap_s2.wide_b;
      r_d.blk_a.size = BRF_SIZE_RST;
      r_d.blk_b.size = BRF_SIZE_RST;
      r_d.blk_a.atime = BRF_TIME_RST;
      r_d.blk_b.atime = BRF_TIME_RST;
      r_d.blk_a.base = r_q.strap_s2.big_a ? BRF_BASE_A_LARGE : BRF_BASE_A_SMALL;
      r_d.blk_b.base = BRF_BASE_B_RST;
    end
  end

  // Single state register
  // No reset term here: reset acts through the next-state logic
  always_ff @(posedge sys_clk) begin
    r_q <= r_d;
  end

endmodule // brf_ctrl
`default_nettype wire

// File: verif/brf_ctrl_props.sv
// Purpose: Port-level checks of the boot ROM/Flash controller.
// Assumes: Straps held steady after reset; requests held until last ack.
// Notes: Block A is wide and block B narrow in the bench setup.
`timescale 1ns/10ps
`default_nettype none
module brf_ctrl_props
  import brf_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire brf_strap_t strap_pins,
  input wire brf_cpu_req_t cpu_req,
  input wire brf_cpu_rsp_t cpu_rsp,
  input wire logic cpu_sel,
  input wire brf_flash_t flash_out,
  input wire logic [63:0] flash_rdata
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  // Reset must leave the device side quiet
  rst_quiet_a: assert property ($fell(reset) |-> flash_out == '0 && !cpu_rsp.ack)
    else $error("device side busy after reset");
  // Wide map skips the rv window, which maps by offset instead
  wide_map_a: assert property (flash_out.ce_a && flash_out.oe && strap_pins.wide_a && !cpu_req.burst
    && cpu_req.addr[31:20] != BRF_RV_WINDOW
    |-> flash_out.addr == cpu_req.addr[25:3] && flash_out.upper && flash_out.lower)
    else $error("wide read address wrong");
  narrow_map_a: assert property (flash_out.ce_b && !strap_pins.wide_b && cpu_req.size == 4'h1
    && !cpu_req.burst
    && cpu_req.addr[31:20] != BRF_RV_WINDOW |-> flash_out.addr == {cpu_req.addr[23:3], cpu_req.addr[1:0]}
    && (!flash_out.we || (flash_out.upper == !cpu_req.addr[2] && flash_out.lower == cpu_req.addr[2])))
    else $error("narrow address or half wrong");
  wr_drive_a: assert property (flash_out.wdata_oe == flash_out.we)
    else $error("data drive not matched to write strobe");
  narrow_wr_a: assert property (flash_out.we && flash_out.ce_b && !strap_pins.wide_b
    |-> cpu_req.size == BRF_WR_SIZE_NARROW) else $error("narrow write of wrong size");
  wide_wr_a: assert property (flash_out.we && flash_out.ce_a && strap_pins.wide_a
    |-> cpu_req.size == BRF_WR_SIZE_WIDE && cpu_req.addr[1:0] == 2'h0) else $error("wide write not 4 aligned");
  wr_cause_a: assert property ($rose(flash_out.we) |-> cpu_req.valid && cpu_req.wr)
    else $error("write strobe without write request");
  last_ack_a: assert property (cpu_rsp.last |-> cpu_rsp.ack)
    else $error("last without ack");
  ack_pulse_a: assert property (cpu_rsp.ack |=> !cpu_rsp.ack)
    else $error("ack longer than one cycle");
  rd_bound_a: assert property ($rose(flash_out.oe) |-> ##[1:80] cpu_rsp.ack)
    else $error("read not answered in time");

  cover property (cpu_rsp.last && cpu_req.burst);
  cover property ($rose(flash_out.we));
  cover property (pslverr);
endmodule // brf_ctrl_props
`default_nettype wire

// File: verif/brf_flash_model.sv
// Purpose: Behavioural ROM/Flash devices behind both blocks.
// Assumes: Data is a fixed pattern of the device address.
// Notes: Deselected pins show the inverse of the last value.
`timescale 1ns/10ps
`default_nettype none
module brf_flash_model
  import brf_pkg::*;
(
  input wire logic sys_clk,
  input wire brf_flash_t flash_out,
  output logic [63:0] flash_rdata
);
  logic [63:0] last_q;
  // Toggle while released so no stale value reads as good
  always_ff @(posedge sys_clk) begin
    last_q <= flash_rdata;
  end
  // Plain 64 data bits, no check bits on this path
  always_comb begin
    if ((flash_out.ce_a || flash_out.ce_b) && flash_out.oe) begin
      flash_rdata = {9'h155, flash_out.addr, 9'h0AA, flash_out.addr};
    end else begin
      flash_rdata = ~last_q;
    end
  end
endmodule // brf_flash_model
`default_nettype wire

// File: verif/brf_ctrl_tb.sv
// Purpose: Self-checking bench of the boot ROM/Flash controller.
// Assumes: Straps give block A wide, block B narrow with reset vector.
// Notes: Bases moved to 64MB-aligned spots so maps read plainly.
`timescale 1ns/10ps
`default_nettype none
module brf_ctrl_tb;
  import brf_pkg::*;
  logic sys_clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0;
  logic [31:0] paddr = '0, pwdata = '0, prdata, r;
  logic pready, pslverr, cpu_sel, err_q, we_seen;
  brf_strap_t strap_pins = 5'h0C;
  brf_cpu_req_t cpu_req = '0;
  brf_cpu_rsp_t cpu_rsp;
  brf_flash_t flash_out;
  logic [63:0] flash_rdata, rd, we_data;
  int err_total = 0, n_checks = 0, cyc = 0, n, bt, we_cnt = 0, we_base;

  brf_ctrl u_dut (.sys_clk(sys_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .strap_pins(strap_pins), .cpu_req(cpu_req), .cpu_rsp(cpu_rsp), .cpu_sel(cpu_sel),
    .flash_out(flash_out), .flash_rdata(flash_rdata));
  brf_flash_model u_mem (.sys_clk(sys_clk), .flash_out(flash_out), .flash_rdata(flash_rdata));

  always #5 sys_clk = ~sys_clk;
  // Record strobes so ignored writes can be told apart
  always @(posedge sys_clk) begin
    cyc++;
    if (flash_out.we) begin
      we_cnt <= we_cnt + 1;
      we_data <= flash_out.wdata;
    end
    if (cyc == 20000) begin
      err_total++;
      wrap_up();
    end
  end

  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= {24'h0, a}; pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    r = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // n counts edges from request to the one that sees last
  task automatic cpu(input logic w, b, input logic [3:0] sz, input logic [31:0] a, input logic [63:0] d);
    n = 0; bt = 0; we_base = we_cnt;
    @(posedge sys_clk);
    cpu_req <= '{1'b1, w, b, sz, a, d};
    do begin
      @(posedge sys_clk);
      n++;
      if (cpu_rsp.ack === 1'b1) begin
        bt++;
        rd = cpu_rsp.rdata;
      end
    end while (cpu_rsp.last !== 1'b1 && n < 2000);
    if (cpu_rsp.last !== 1'b1) begin
      err_total++;
      $display("ERROR cpu_last exp 1 got %b", cpu_rsp.last);
    end
    cpu_req.valid <= 1'b0;
    @(posedge sys_clk);
    we_seen = (we_cnt != we_base);
  endtask

  task automatic probe(input logic [31:0] a);
    @(posedge sys_clk);
    cpu_req <= '{1'b1, 1'b0, 1'b0, 4'h1, a, 64'h0};
    repeat (2) @(posedge sys_clk);
    chk("cpu_sel", 64'h0, 64'(cpu_sel));
    cpu_req.valid <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic t_regs;
    apb(1'b0, BRF_OFF_CTRL_A, 32'h0); chk("ctrl_a", 64'h0F08, 64'(r));
    apb(1'b0, BRF_OFF_CTRL_B, 32'h0); chk("ctrl_b", 64'h0F04, 64'(r));
    apb(1'b0, BRF_OFF_BASE_A, 32'h0); chk("base_a", 64'hFF000000, 64'(r));
    apb(1'b0, BRF_OFF_BASE_B, 32'h0); chk("base_b", 64'hFF800000, 64'(r));
    apb(1'b1, BRF_OFF_CTRL_A, 32'h0);
    apb(1'b0, BRF_OFF_CTRL_A, 32'h0); chk("width ro", 64'h0008, 64'(r));
    apb(1'b1, BRF_OFF_BASE_A, 32'h14000000);
    apb(1'b0, BRF_OFF_BASE_A, 32'h0); chk("base_a wr", 64'h14000000, 64'(r));
    apb(1'b1, BRF_OFF_BASE_B, 32'h20000000);
    apb(1'b0, 8'h10, 32'h0); chk("unmapped", 64'h1, 64'(err_q));
    $display("t_regs done");
  endtask

  task automatic t_wide;
    apb(1'b1, BRF_OFF_CTRL_A, 32'h0101);
    cpu(1'b0, 1'b0, 4'h8, 32'h14000010, 64'h0);
    chk("wide rd", {9'h155, 23'h2, 9'h0AA, 23'h2}, rd);
    chk("wide t1", 64'h5, 64'(n));
    apb(1'b1, BRF_OFF_CTRL_A, 32'h0401);
    cpu(1'b0, 1'b0, 4'h8, 32'h14000010, 64'h0); chk("wide t4", 64'h8, 64'(n));
    cpu(1'b0, 1'b1, 4'h8, 32'h14000020, 64'h0); chk("beats", 64'h4, 64'(bt));
    apb(1'b1, BRF_OFF_CTRL_A, 32'h0100);
    probe(32'h14000010);
    $display("t_wide done");
  endtask

  task automatic t_narrow;
    apb(1'b1, BRF_OFF_CTRL_B, 32'h0105);
    cpu(1'b0, 1'b0, 4'h1, 32'h2000000D, 64'h0);
    chk("byte", 64'h05, 64'(rd[23:16]));
    chk("byte t", 64'h5, 64'(n));
    cpu(1'b0, 1'b0, 4'h8, 32'h20000008, 64'h0);
    chk("dword", 64'h0405060704050607, rd);
    chk("dword t", 64'd14, 64'(n));
    $display("t_narrow done");
  endtask

  task automatic t_write;
    cpu(1'b1, 1'b0, 4'h1, 32'h20000005, 64'h5A0000); chk("we off", 64'h0, 64'(we_seen));
    chk("drop t", 64'h2, 64'(n));
    apb(1'b1, BRF_OFF_CTRL_B, 32'h0107);
    cpu(1'b1, 1'b0, 4'h4, 32'h20000004, 64'h0); chk("nw size", 64'h0, 64'(we_seen));
    chk("nw t", 64'h2, 64'(n));
    cpu(1'b1, 1'b0, 4'h1, 32'h20000005, 64'h5A0000); chk("nw ok", 64'h1, 64'(we_seen));
    chk("nw lane", 64'h5A, 64'(we_data[7:0]));
    apb(1'b1, BRF_OFF_CTRL_A, 32'h0103);
    cpu(1'b1, 1'b0, 4'h4, 32'h14000008, 64'h1234567800000000);
    chk("ww data", 64'h12345678, 64'(we_data[63:32]));
    cpu(1'b1, 1'b0, 4'h2, 32'h14000008, 64'h0); chk("ww size", 64'h0, 64'(we_seen));
    chk("ww t", 64'h2, 64'(n));
    $display("t_write done");
  endtask

  task automatic t_rv;
    apb(1'b1, BRF_OFF_CTRL_B, 32'h0104);
    cpu(1'b0, 1'b0, 4'h1, 32'hFFF00009, 64'h0); chk("rv byte", 64'h05, 64'(rd[55:48]));
    apb(1'b1, BRF_OFF_CTRL_B, 32'h0100);
    probe(32'hFFF00009);
    $display("t_rv done");
  endtask

  task automatic wrap_up;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (5) @(posedge sys_clk);
    reset <= 1'b0;
    t_regs();
    t_wide();
    t_narrow();
    t_write();
    t_rv();
    wrap_up();
  end
endmodule // brf_ctrl_tb

bind brf_ctrl brf_ctrl_props u_props (.sys_clk(sys_clk), .reset(reset), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .strap_pins(strap_pins), .cpu_req(cpu_req), .cpu_rsp(cpu_rsp), .cpu_sel(cpu_sel),
  .flash_out(flash_out), .flash_rdata(flash_rdata));
`default_nettype wire
